// File: rtl/twmbe_pkg.sv
// package: constants and types shared by the two-wire master byte engine
package twmbe_pkg;

   // -------------------------------------------------------------------
   // timebase
   // -------------------------------------------------------------------
   localparam int CLK_MHZ    = 25;       // system clock rate
   localparam int PERIPH_MHZ = 16;       // reference rate of the prescaler
   localparam int PRE_W      = 8;        // prescaler field width
   localparam int ACC_W      = 6;
   // fractional stepping turns 25 MHz into an average 16 MHz tick
   localparam logic [ACC_W-1:0] ACC_STEP  = ACC_W'(PERIPH_MHZ);
   localparam logic [ACC_W-1:0] ACC_MOD   = ACC_W'(CLK_MHZ);
   localparam logic [ACC_W-1:0] ACC_RESET = 6'h00;

   // -------------------------------------------------------------------
   // bit framing: five prescaled phases per serial clock period
   // -------------------------------------------------------------------
   localparam logic [2:0] PH_FIRST = 3'h0;
   localparam logic [2:0] PH_DATA  = 3'h1;   // data line may change
   localparam logic [2:0] PH_HIGH  = 3'h3;   // clock released from here
   localparam logic [2:0] PH_LAST  = 3'h4;
   localparam logic [2:0] BIT_MSB  = 3'h7;
   localparam logic [2:0] BIT_LSB  = 3'h0;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // -------------------------------------------------------------------
   // command word and engine states
   // -------------------------------------------------------------------
   typedef struct packed {
      logic start;
      logic stop;
      logic write;
      logic read;
      logic nack;      // answer a read byte with not-acknowledge
   } twmbe_cmd_t;

   localparam twmbe_cmd_t CMD_NONE = '0;

   typedef enum logic [2:0] {
      ST_IDLE,     // bus released
      ST_HOLD,     // bus owned, clock held low between commands
      ST_START,
      ST_BIT,
      ST_ACK,
      ST_STOP
   } twmbe_state_t;

endpackage

// File: rtl/twmbe_sync.sv
// two flip-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
module twmbe_sync
   import twmbe_pkg::*;
#(
   parameter int W = 1
)(
   input  wire logic         clock_in,
   input  wire logic         rstn_in,
   input  wire logic [W-1:0] d_in,
   output logic      [W-1:0] q_out
);

   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   // released lines idle high, so reset to ones
   always_comb begin
      meta_nxt = d_in;
      q_nxt    = meta_r;
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         meta_r <= '1;
         q_out  <= '1;
      end else begin
         meta_r <= meta_nxt;
         q_out  <= q_nxt;
      end
   end

endmodule

// File: rtl/twmbe_top.sv
// two-wire bus master byte engine: staged buffer, commands, line drive
`timescale 1ns/1ns
module twmbe_top
   import twmbe_pkg::*;
(
   input  wire logic             clock_in,
   input  wire logic             rstn_in,
   input  wire logic             master_en_in,
   input  wire logic             slave_en_in,
   input  wire logic             irq_en_in,
   input  wire logic             irq_ack_in,
   input  wire logic [PRE_W-1:0] prescale_in,
   input  wire logic             stage_target_address_in,
   input  wire logic [6:0]       target_addr_in,
   input  wire logic             target_read_in,
   input  wire logic             stage_tx_byte_in,
   input  wire logic [7:0]       tx_byte_in,
   input  wire logic             issue_bus_command_in,
   input  wire twmbe_cmd_t       bus_cmd_in,
   input  wire logic             scl_in,
   input  wire logic             sda_in,
   output logic                  scl_out,
   output logic                  scl_oe_out,
   output logic                  sda_out,
   output logic                  sda_oe_out,
   output logic [7:0]            fetch_rx_byte_out,
   output twmbe_cmd_t            cmd_pending_out,
   output logic                  busy_out,
   output logic                  read_nack_status_out,
   output logic                  read_arb_lost_status_out,
   output logic                  serial_port_irq_source_out
);

   // -------------------------------------------------------------------
   // pin synchronisers
   // -------------------------------------------------------------------
   logic [1:0] pins_s;
   logic       scl_s;
   logic       sda_s;

   twmbe_sync #(.W(2)) u_sync (
      .clock_in (clock_in),
      .rstn_in  (rstn_in),
      .d_in     ({scl_in, sda_in}),
      .q_out    (pins_s)
   );
   assign scl_s = pins_s[1];
   assign sda_s = pins_s[0];

   // -------------------------------------------------------------------
   // state
   // -------------------------------------------------------------------
   twmbe_state_t     st_r,  st_nxt;
   twmbe_cmd_t       cmd_r, cmd_nxt;
   logic [ACC_W-1:0] acc_r, acc_nxt;
   logic [PRE_W-1:0] pre_r, pre_nxt;
   logic [2:0]       ph_r,  ph_nxt;
   logic [2:0]       bit_r, bit_nxt;
   logic [7:0]       sh_r,  sh_nxt;
   logic [7:0]       txb_r, txb_nxt;
   logic [7:0]       rx_r,  rx_nxt;
   logic             wr_r,  wr_nxt;
   logic             nack_r, nack_nxt;
   logic             arb_r, arb_nxt;
   logic             irq_r, irq_nxt;
   logic             scl_oe_r, scl_oe_nxt;
   logic             sda_oe_r, sda_oe_nxt;
   logic             tick16, ph_tick, adv, stretch;
   logic             active, idle_ok, take, done, arb_evt;

   assign active  = master_en_in & ~slave_en_in;
   assign idle_ok = (st_r == ST_IDLE) || (st_r == ST_HOLD);
   assign take    = issue_bus_command_in & active & idle_ok;

   // -------------------------------------------------------------------
   // timebase: average 16 MHz tick, divided by prescale+1 per phase
   // -------------------------------------------------------------------
   // a slave holding the clock low stretches the high phase; with tiny
   // prescale values the pin synchroniser latency eats into phase 3
   always_comb begin
      tick16  = 1'b0;
      ph_tick = 1'b0;
      acc_nxt = acc_r + ACC_STEP;
      if (acc_nxt >= ACC_MOD) begin
         acc_nxt = acc_nxt - ACC_MOD;
         tick16  = 1'b1;
      end
      pre_nxt = pre_r;
      if (idle_ok) begin
         pre_nxt = '0;
      end else if (tick16) begin
         if (pre_r == prescale_in) begin
            pre_nxt = '0;
            ph_tick = 1'b1;
         end else begin
            pre_nxt = pre_r + 1'b1;
         end
      end
      stretch = (ph_r == PH_HIGH) && !scl_oe_r && !scl_s;
      adv     = ph_tick & ~stretch;
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         acc_r <= ACC_RESET;
         pre_r <= '0;
      end else begin
         acc_r <= acc_nxt;
         pre_r <= pre_nxt;
      end
   end

   // -------------------------------------------------------------------
   // byte engine
   // -------------------------------------------------------------------
   always_comb begin
      st_nxt   = st_r;
      cmd_nxt  = cmd_r;
      ph_nxt   = ph_r;
      bit_nxt  = bit_r;
      sh_nxt   = sh_r;
      txb_nxt  = txb_r;
      rx_nxt   = rx_r;
      wr_nxt   = wr_r;
      nack_nxt = nack_r;
      arb_nxt  = arb_r;
      done     = 1'b0;
      arb_evt  = 1'b0;
      // staging only fills the buffer; ignored while a byte is moving
      if (idle_ok && stage_target_address_in) begin
         txb_nxt = {target_addr_in, target_read_in};
      end else if (idle_ok && stage_tx_byte_in) begin
         txb_nxt = tx_byte_in;
      end
      if (take) begin
         cmd_nxt = bus_cmd_in;
         arb_nxt = 1'b0;
         ph_nxt  = PH_FIRST;
         bit_nxt = BIT_MSB;
         sh_nxt  = txb_r;
         wr_nxt  = ~bus_cmd_in.read;
         if (bus_cmd_in.start) begin
            st_nxt = ST_START;
         end else if (bus_cmd_in.write || bus_cmd_in.read) begin
            st_nxt = ST_BIT;
         end else if (bus_cmd_in.stop && st_r == ST_HOLD) begin
            st_nxt = ST_STOP;
         end else begin
            cmd_nxt = CMD_NONE;
         end
      end else if (adv) begin
         ph_nxt = (ph_r == PH_LAST) ? PH_FIRST : ph_r + 1'b1;
         if (ph_r == PH_LAST) begin
            case (st_r)
               ST_START: begin
                  st_nxt = ST_BIT;
               end
               ST_BIT: begin
                  sh_nxt = {sh_r[6:0], sda_s};
                  if (wr_r && !sda_oe_r && !sda_s) begin
                     st_nxt  = ST_IDLE;
                     cmd_nxt = CMD_NONE;
                     arb_nxt = 1'b1;
                     arb_evt = 1'b1;
                  end else if (bit_r == BIT_LSB) begin
                     st_nxt = ST_ACK;
                  end else begin
                     bit_nxt = bit_r - 1'b1;
                  end
               end
               ST_ACK: begin
                  if (wr_r) begin
                     nack_nxt = sda_s;
                  end else begin
                     rx_nxt = sh_r;
                  end
                  if (cmd_r.stop) begin
                     st_nxt = ST_STOP;
                  end else begin
                     st_nxt  = ST_HOLD;
                     cmd_nxt = CMD_NONE;
                     done    = 1'b1;
                  end
               end
               ST_STOP: begin
                  st_nxt  = ST_IDLE;
                  cmd_nxt = CMD_NONE;
                  done    = 1'b1;
               end
               default: begin
                  st_nxt = st_r;
               end
            endcase
         end
      end
      if (!active) begin
         st_nxt  = ST_IDLE;
         cmd_nxt = CMD_NONE;
      end
   end

   // -------------------------------------------------------------------
   // line drive, status and interrupt
   // -------------------------------------------------------------------
   // data only moves one phase after the clock falls, so no edge of the
   // data line can look like a start or stop by accident, except when active drops mid-transfer and both lines are released in the same cycle
   always_comb begin
      scl_oe_nxt = 1'b0;
      sda_oe_nxt = 1'b0;
      case (st_nxt == ST_IDLE ? ST_IDLE : st_r)
         ST_IDLE: begin
            scl_oe_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
         end
         ST_HOLD: begin
            scl_oe_nxt = 1'b1;
            sda_oe_nxt = sda_oe_r;
         end
         ST_START: begin
            scl_oe_nxt = (ph_r == PH_FIRST) ? scl_oe_r : 1'b0;
            sda_oe_nxt = (ph_r >= PH_HIGH);
         end
         ST_BIT: begin
            scl_oe_nxt = (ph_r < PH_HIGH);
            sda_oe_nxt = (ph_r == PH_FIRST) ? sda_oe_r
                                            : (wr_r & ~sh_r[7]);
         end
         ST_ACK: begin
            scl_oe_nxt = (ph_r < PH_HIGH);
            sda_oe_nxt = (ph_r == PH_FIRST) ? sda_oe_r
                                            : (~wr_r & ~cmd_r.nack);
         end
         ST_STOP: begin
            scl_oe_nxt = (ph_r < PH_HIGH);
            sda_oe_nxt = (ph_r == PH_FIRST) ? sda_oe_r
                                            : (ph_r < PH_LAST);
         end
         default: begin
            scl_oe_nxt = 1'b0;
            sda_oe_nxt = 1'b0;
         end
      endcase
      // a new event wins over an acknowledge in the same cycle
      irq_nxt = irq_r & ~irq_ack_in;
      if (irq_en_in && (done || arb_evt)) begin
         irq_nxt = 1'b1;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         st_r     <= ST_IDLE;
         cmd_r    <= CMD_NONE;
         ph_r     <= PH_FIRST;
         bit_r    <= BIT_MSB;
         sh_r     <= BYTE_RESET;
         txb_r    <= BYTE_RESET;
         rx_r     <= BYTE_RESET;
         wr_r     <= 1'b1;
         nack_r   <= 1'b0;
         arb_r    <= 1'b0;
         irq_r    <= 1'b0;
         scl_oe_r <= 1'b0;
         sda_oe_r <= 1'b0;
         busy_out <= 1'b0;
      end else begin
         st_r     <= st_nxt;
         cmd_r    <= cmd_nxt;
         ph_r     <= ph_nxt;
         bit_r    <= bit_nxt;
         sh_r     <= sh_nxt;
         txb_r    <= txb_nxt;
         rx_r     <= rx_nxt;
         wr_r     <= wr_nxt;
         nack_r   <= nack_nxt;
         arb_r    <= arb_nxt;
         irq_r    <= irq_nxt;
         scl_oe_r <= scl_oe_nxt;
         sda_oe_r <= sda_oe_nxt;
         busy_out <= (st_nxt != ST_IDLE) && (st_nxt != ST_HOLD);
      end
   end

   // open-drain: the driven level is always low
   assign scl_out                    = 1'b0;
   assign sda_out                    = 1'b0;
   assign scl_oe_out                 = scl_oe_r;
   assign sda_oe_out                 = sda_oe_r;
   assign fetch_rx_byte_out          = rx_r;
   assign cmd_pending_out            = cmd_r;
   assign read_nack_status_out       = nack_r;
   assign read_arb_lost_status_out   = arb_r;
   assign serial_port_irq_source_out = irq_r;

   // -------------------------------------------------------------------
   // assertions
   // -------------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rstn_in);

   sequence s_ack_end;
      st_r == ST_ACK && adv && ph_r == PH_LAST;
   endsequence

   a_idle_quiet: assert property (
      st_r == ST_IDLE && $past(st_r) == ST_IDLE |->
         !scl_oe_out && !sda_oe_out)
      else $error("lines driven while idle");
   a_stage_only: assert property (
      idle_ok && stage_target_address_in && !issue_bus_command_in
         |=> st_r == $past(st_r))
      else $error("staging changed engine state");
   a_start_shape: assert property (
      $rose(sda_oe_out) && !scl_oe_out |-> $past(st_r) == ST_START)
      else $error("data fell with clock high outside start");
   a_plain_write: assert property (
      take && !bus_cmd_in.start && bus_cmd_in.write |=> st_r == ST_BIT)
      else $error("plain write did not go straight to bits");
   a_ack_drive: assert property (
      st_r == ST_ACK && ph_r == PH_DATA && !wr_r |=>
         sda_oe_out == !cmd_r.nack)
      else $error("wrong acknowledge level on read");
   a_nack_rec: assert property (
      s_ack_end and wr_r |=> read_nack_status_out == $past(sda_s))
      else $error("slave answer not recorded");
   a_rx_hold: assert property (
      s_ack_end and !wr_r |=> fetch_rx_byte_out == $past(sh_r))
      else $error("received byte not captured");
   a_busy_flag: assert property (
      take && bus_cmd_in.write |=> busy_out)
      else $error("busy not raised for transfer");
   a_stop_free: assert property (
      st_r == ST_STOP ##1 st_r == ST_IDLE |=>
         !sda_oe_out && !scl_oe_out && cmd_pending_out == CMD_NONE)
      else $error("bus not released after stop");
   a_irq_event: assert property (
      irq_en_in && (done || arb_evt) |=> serial_port_irq_source_out)
      else $error("interrupt missed");
   a_arb_flag: assert property (
      arb_evt |=> read_arb_lost_status_out && st_r == ST_IDLE)
      else $error("arbitration loss not flagged");
   a_one_role: assert property (
      slave_en_in |=> st_r == ST_IDLE)
      else $error("master engine ran in slave mode");

endmodule

// File: sim/twmbe_slave_model.sv
// behavioural two-wire slave that answers the byte engine on the wire
`timescale 1ns/1ns
module twmbe_slave_model
   import twmbe_pkg::*;
#(
   parameter logic [6:0] ADDR = 7'h79
)(
   input  wire logic       scl_in,
   input  wire logic       sda_in,
   input  wire logic       nack_in,
   output logic            sda_oe_out,
   output logic [7:0]      last_byte_out,
   output logic            mack_out
);
   // -------------------------------------------------------------------
   // frame state
   // -------------------------------------------------------------------
   int         cnt;
   logic [7:0] sh, txd;
   logic       act, adr, rd, skip, ok;

   initial begin
      {sda_oe_out, mack_out, act, adr, rd, skip, ok} = 7'h00;
      last_byte_out = 8'h00;
      sh = 8'h00;
      txd = 8'h00;
      cnt = 0;
   end

   // start: data falls while the clock is high, even when repeated
   always @(negedge sda_in) begin
      if (scl_in) begin
         {act, adr, rd, skip} = 4'hd;
         cnt = 0;
         txd = 8'ha4;
      end
   end

   // stop: data rises while the clock is high, the slave lets go
   always @(posedge sda_in) begin
      if (scl_in) begin
         act = 1'b0;
         sda_oe_out = 1'b0;
      end
   end

   // -------------------------------------------------------------------
   // bit sampling and driving
   // -------------------------------------------------------------------
   always @(posedge scl_in) begin
      if (act && cnt < 8) sh = {sh[6:0], sda_in};
      else if (act && rd && !adr) mack_out = !sda_in;
   end

   // all changes land while the clock is low, never inside a high phase
   always @(negedge scl_in) begin
      if (skip) skip = 1'b0;
      else if (act && cnt < 7) begin
         cnt = cnt + 1;
         if (rd && !adr) sda_oe_out = !txd[7-cnt];
      end else if (act && cnt == 7) begin
         cnt = 8;
         ok = 1'b1;
         if (rd && !adr) sda_oe_out = 1'b0;   // master answers this slot
         else begin
            ok = (!adr || sh[7:1] == ADDR) && !nack_in;
            sda_oe_out = ok;
            last_byte_out = sh;
            if (adr) rd = sh[0] && ok;
         end
      end else if (act) begin
         cnt = 0;
         if (rd && (adr || mack_out)) begin
            txd = txd + 8'h01;
            sda_oe_out = !txd[7];
         end else sda_oe_out = 1'b0;
         adr = 1'b0;
         act = ok;   // a refused slave ignores the rest of the frame
      end
   end
endmodule

// File: sim/tb_top.sv
// self-checking bench: command sequences, wire checks, refusals
`timescale 1ns/1ns
module tb_top
   import twmbe_pkg::*;
;
   // -------------------------------------------------------------------
   // signals
   // -------------------------------------------------------------------
   localparam logic [PRE_W-1:0] PRE = 8'h02;
   localparam int EXP_PER = 5 * (int'(PRE) + 1) * CLK_MHZ / PERIPH_MHZ;
   localparam int CEIL    = 20000;
   logic       clock_in, rstn_in, men, sen, ien, iack, sta, tra, stb, iss;
   logic       rival, snack, scl_o, scl_oe, sda_o, sda_oe, busy, nst, arb;
   logic       irq, s_oe, s_mack, scl_q;
   logic [6:0] tad;
   logic [7:0] txb, rxb, s_last;
   twmbe_cmd_t cmd, pend;
   wire logic  scl_w, sda_w;
   int         bad_count, checked, cycles, per, last_per;

   // open-drain wires with pull-ups: any enable pulls low
   assign scl_w = !scl_oe;
   assign sda_w = !(sda_oe | s_oe | rival);

   twmbe_top u_dut (.clock_in(clock_in), .rstn_in(rstn_in),
      .master_en_in(men), .slave_en_in(sen), .irq_en_in(ien),
      .irq_ack_in(iack), .prescale_in(PRE), .stage_target_address_in(sta),
      .target_addr_in(tad), .target_read_in(tra), .stage_tx_byte_in(stb),
      .tx_byte_in(txb), .issue_bus_command_in(iss), .bus_cmd_in(cmd),
      .scl_in(scl_w), .sda_in(sda_w), .scl_out(scl_o), .scl_oe_out(scl_oe),
      .sda_out(sda_o), .sda_oe_out(sda_oe), .fetch_rx_byte_out(rxb),
      .cmd_pending_out(pend), .busy_out(busy), .read_nack_status_out(nst),
      .read_arb_lost_status_out(arb), .serial_port_irq_source_out(irq));

   twmbe_slave_model u_slave (.scl_in(scl_w), .sda_in(sda_w),
      .nack_in(snack), .sda_oe_out(s_oe), .last_byte_out(s_last),
      .mack_out(s_mack));

   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end

   // serial clock period and run-time ceiling, in system clocks
   always @(posedge clock_in) begin
      scl_q <= scl_w;
      per <= (scl_w && !scl_q) ? 1 : per + 1;
      if (scl_w && !scl_q) last_per <= per;
      cycles <= cycles + 1;
      if (cycles == CEIL) begin
         bad_count++;
         conclude();
      end
   end

   // -------------------------------------------------------------------
   // tasks
   // -------------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic chk1(input logic seen, input logic exp);
      check({7'h00, seen}, {7'h00, exp});
   endtask

   task automatic conclude();
      $display("checks %0d, mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   // adr high stages {address, direction}, low stages a data byte
   task automatic stage(input logic adr, input logic [7:0] v);
      @(posedge clock_in);
      sta <= adr;
      stb <= !adr;
      tad <= v[7:1];
      tra <= v[0];
      txb <= v;
      @(posedge clock_in);
      sta <= 1'b0;
      stb <= 1'b0;
   endtask

   // one command, then a bounded wait for completion
   task automatic run(input twmbe_cmd_t c, input logic take);
      int i;
      @(posedge clock_in);
      iss <= 1'b1;
      cmd <= c;
      @(posedge clock_in);
      iss <= 1'b0;
      @(posedge clock_in);
      #1;
      check({3'h0, pend}, take ? {3'h0, c} : 8'h00);
      chk1(busy, take);
      for (i = 0; i < 3000 && (busy !== 1'b0 || pend !== CMD_NONE); i++)
         @(posedge clock_in);
      #1;
      check({3'h0, pend}, 8'h00);
   endtask

   task automatic clear_irq();
      @(posedge clock_in);
      iack <= 1'b1;
      @(posedge clock_in);
      iack <= 1'b0;
      @(posedge clock_in);
      #1;
      chk1(irq, 1'b0);
   endtask

   // -------------------------------------------------------------------
   // main sequence; command codes are {start,stop,write,read,nack}
   // -------------------------------------------------------------------
   initial begin
      {rstn_in, sen, iack, sta, stb, tra, iss, rival, snack} = 9'h000;
      {men, ien} = 2'h3;
      {tad, txb, cmd} = '0;
      {bad_count, checked, cycles, per, last_per} = '0;
      repeat (8) @(posedge clock_in);
      rstn_in <= 1'b1;
      #1;
      check({scl_oe, sda_oe, busy, irq, nst, arb, scl_o, sda_o} | rxb,
            8'h00);
      stage(1'b1, 8'hf2);
      repeat (20) @(posedge clock_in);
      #1;
      chk1(scl_oe | sda_oe, 1'b0);
      sen <= 1'b1;
      run(5'h14, 1'b0);
      sen <= 1'b0;
      // 10-bit write: prefix, low address bits, last byte with stop
      run(5'h14, 1'b1);
      check(s_last, 8'hf2);
      chk1(nst, 1'b0);
      chk1(irq, 1'b1);
      clear_irq();
      stage(1'b0, 8'h34);
      run(5'h04, 1'b1);
      check(s_last, 8'h34);
      chk1(scl_oe, 1'b1);
      chk1(last_per >= EXP_PER - 1 && last_per <= EXP_PER + 2, 1'b1);
      stage(1'b0, 8'h5a);
      run(5'h0c, 1'b1);
      check(s_last, 8'h5a);
      chk1(scl_w & sda_w, 1'b1);
      // 10-bit read: full address, repeated start with read prefix
      stage(1'b1, 8'hf2);
      run(5'h14, 1'b1);
      stage(1'b0, 8'h34);
      run(5'h04, 1'b1);
      stage(1'b1, 8'hf3);
      run(5'h14, 1'b1);
      run(5'h02, 1'b1);
      check(rxb, 8'ha5);
      chk1(s_mack, 1'b1);
      run(5'h0b, 1'b1);
      check(rxb, 8'ha6);
      chk1(s_mack, 1'b0);
      chk1(scl_w & sda_w, 1'b1);
      // refused address: nack kept, software stops, no irq when masked
      snack <= 1'b1;
      stage(1'b1, 8'hf2);
      run(5'h14, 1'b1);
      chk1(nst, 1'b1);
      clear_irq();
      ien <= 1'b0;
      run(5'h08, 1'b1);
      chk1(scl_w & sda_w, 1'b1);
      chk1(irq, 1'b0);
      run(5'h08, 1'b0);
      snack <= 1'b0;
      ien <= 1'b1;
      // a rival master holds data low while our byte goes out
      stage(1'b1, 8'hf2);
      run(5'h14, 1'b1);
      clear_irq();
      rival <= 1'b1;
      stage(1'b0, 8'hff);
      run(5'h04, 1'b1);
      chk1(arb, 1'b1);
      chk1(irq, 1'b1);
      chk1(scl_oe | sda_oe, 1'b0);
      rival <= 1'b0;
      clear_irq();
      stage(1'b1, 8'hf2);
      run(5'h14, 1'b1);
      chk1(arb, 1'b0);
      run(5'h08, 1'b1);
      conclude();
   end
endmodule
